// ==== hw/record_fifo.sv ====
// Small synchronous record queue with honest full and empty
`timescale 1ns/100ps
module record_fifo #(
   parameter int WIDTH = 6,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              sys_rst,
   // Fill side
   input  wire logic              push_valid,
   output logic                   push_ready,
   input  wire logic [WIDTH-1:0]  push_data,
   // Drain side
   output logic                   pop_valid,
   input  wire logic              pop_ready,
   output logic [WIDTH-1:0]       pop_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [PW:0]      cnt_q, cnt_d;
   logic             do_push, do_pop;

   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign push_ready = (cnt_q != (PW+1)'(DEPTH));
   assign pop_valid  = (cnt_q != '0);
   assign pop_data   = mem_q[rd_q];
   assign level      = cnt_q;
   assign do_push    = push_valid && push_ready;
   assign do_pop     = pop_valid && pop_ready;

   always_comb begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (do_push) begin
         mem_d[wr_q] = push_data;
         wr_d        = next_ptr(wr_q);
      end
      if (do_pop) begin
         rd_d = next_ptr(rd_q);
      end
      case ({do_push, do_pop})
         2'b10:   cnt_d = cnt_q + 1'b1;
         2'b01:   cnt_d = cnt_q - 1'b1;
         default: cnt_d = cnt_q;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
         mem_q <= mem_d;
      end
   end
endmodule

// ==== hw/usb_transfer_status_fifo.sv ====
// Transfer status queue with register port and interrupt
`timescale 1ns/100ps
module usb_transfer_status_fifo #(
   parameter int DEPTH = xfer_status_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                                clock,
   input  wire logic                                sys_rst,
   // Register port
   input  wire logic [xfer_status_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [xfer_status_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                                reg_write,
   input  wire logic                                reg_read,
   output logic [xfer_status_pkg::DATA_W-1:0]       reg_rdata,
   // Transaction engine side
   input  wire logic                                xfer_done,
   input  wire logic [xfer_status_pkg::EP_W-1:0]    xfer_endpoint,
   input  wire logic                                xfer_transmit,
   input  wire logic                                xfer_odd_bank,
   output logic                                     xfer_ready,
   // Status outputs
   output logic                                     transfer_complete_flag,
   output logic                                     irq
);
   import xfer_status_pkg::*;

   // Width of the record count
   localparam int CNT_W = $clog2(DEPTH) + 1;

   // Record from the transaction engine
   logic [REC_W-1:0]        push_rec;
   logic                    push_drop;
   // Head of the queue
   logic [REC_W-1:0]        head_rec;
   logic                    head_valid;
   logic [EP_W-1:0]         head_endpoint;
   logic                    head_transmit;
   logic                    head_odd_bank;
   logic [DATA_W-1:0]       head_status;
   logic [CNT_W-1:0]        level;
   // Register port decode
   logic                    rd_status;
   logic                    rd_flags;
   logic                    rd_mask;
   logic                    rd_count;
   logic                    wr_flags;
   logic                    wr_mask;
   logic                    pop_req;
   // Interrupt state
   logic [FLAG_W-1:0]       flags;
   logic [FLAG_W-1:0]       mask_q;
   logic [FLAG_W-1:0]       mask_d;
   logic                    ovf_q;
   logic                    ovf_d;
   // Read data register
   logic [DATA_W-1:0]       rdata_q;
   logic [DATA_W-1:0]       rdata_d;

   // True when a strobe hits one register offset
   function automatic logic addr_hit(input logic              strobe,
                                     input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] target);
      addr_hit = strobe && (addr == target);
   endfunction

   // Packs the engine's report into one queue record
   function automatic logic [REC_W-1:0] pack_record(input logic [EP_W-1:0] endpoint,
                                                    input logic            transmit,
                                                    input logic            odd_bank);
      logic [REC_W-1:0] rec;
      rec                  = '0;
      rec[REC_W-1 -: EP_W] = endpoint;
      rec[REC_DIR_POS]     = transmit;
      rec[REC_BANK_POS]    = odd_bank;
      pack_record = rec;
   endfunction

   // Status word; pad bits and an empty queue read as zero
   function automatic logic [DATA_W-1:0] status_word(input logic            valid,
                                                     input logic [EP_W-1:0] endpoint,
                                                     input logic            transmit,
                                                     input logic            odd_bank);
      logic [DATA_W-1:0] word;
      word = '0;
      if (valid) begin
         word[EP_LSB +: EP_W] = endpoint;
         word[DIR_BIT]        = transmit;
         word[BANK_BIT]       = odd_bank;
      end
      status_word = word;
   endfunction

   // Flag byte: live transfer bit and sticky overflow
   function automatic logic [FLAG_W-1:0] flag_byte(input logic waiting,
                                                   input logic dropped);
      logic [FLAG_W-1:0] value;
      value               = '0;
      value[TRN_FLAG_BIT] = waiting;
      value[OVF_FLAG_BIT] = dropped;
      flag_byte = value;
   endfunction

   // Zero-extends a flag-wide register into a bus word
   function automatic logic [DATA_W-1:0] byte_word(input logic [FLAG_W-1:0] value);
      byte_word = {{(DATA_W - FLAG_W){1'b0}}, value};
   endfunction

   // Zero-extends the record count into a bus word
   function automatic logic [DATA_W-1:0] count_word(input logic [CNT_W-1:0] value);
      count_word = {{(DATA_W - CNT_W){1'b0}}, value};
   endfunction

   // Offsets not decoded read as zero and ignore writes
   assign rd_status = addr_hit(reg_read, reg_addr, ADDR_STATUS);
   assign rd_flags  = addr_hit(reg_read, reg_addr, ADDR_FLAGS);
   assign rd_mask   = addr_hit(reg_read, reg_addr, ADDR_MASK);
   assign rd_count  = addr_hit(reg_read, reg_addr, ADDR_COUNT);
   assign wr_flags  = addr_hit(reg_write, reg_addr, ADDR_FLAGS);
   assign wr_mask   = addr_hit(reg_write, reg_addr, ADDR_MASK);

   // Record pushed on every completed transfer that finds room in the queue
   assign push_rec  = pack_record(xfer_endpoint,
                                  xfer_transmit,
                                  xfer_odd_bank);
   // A report that finds the queue full is dropped and flagged
   assign push_drop = xfer_done && !xfer_ready;

   record_fifo #(
      .WIDTH (REC_W),
      .DEPTH (DEPTH)
   ) u_queue (
      // Clock and reset
      .clock      (clock),
      .sys_rst    (sys_rst),
      // Fill side
      .push_valid (xfer_done),
      .push_ready (xfer_ready),
      .push_data  (push_rec),
      // Drain side
      .pop_valid  (head_valid),
      .pop_ready  (pop_req),
      .pop_data   (head_rec),
      .level      (level)
   );

   // Fields of the oldest record
   assign head_endpoint = head_rec[REC_W-1 -: EP_W];
   assign head_transmit = head_rec[REC_DIR_POS];
   assign head_odd_bank = head_rec[REC_BANK_POS];
   assign head_status   = status_word(head_valid,
                                      head_endpoint,
                                      head_transmit,
                                      head_odd_bank);

   // Flag follows the queue, so it stays up while records wait
   assign transfer_complete_flag = head_valid;

   // Writing one to the flag bit pops the head record
   assign pop_req = wr_flags && reg_wdata[TRN_FLAG_BIT];

   assign flags = flag_byte(head_valid, ovf_q);

   // Level interrupt from the flag byte and its mask
   assign irq = |(flags & mask_q);

   // Interrupt mask; only defined flag bits can be enabled
   always_comb begin
      mask_d = mask_q;
      if (wr_mask) begin
         mask_d = reg_wdata[FLAG_W-1:0] & FLAG_USED;
      end
   end

   // Mask resets to all sources disabled
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mask_q <= MASK_RESET;
      end else begin
         mask_q <= mask_d;
      end
   end

   // Sticky overflow; a read of the flag register clears it, a new drop in that cycle wins
   always_comb begin
      ovf_d = ovf_q;
      if (rd_flags) begin
         ovf_d = 1'b0;
      end
      if (push_drop) begin
         ovf_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= ovf_d;
      end
   end

   // Read data stands for the cycle after the strobe, zero otherwise
   always_comb begin
      rdata_d = '0;
      if (rd_status) begin
         rdata_d = head_status;
      end else if (rd_flags) begin
         rdata_d = byte_word(flags);
      end else if (rd_mask) begin
         rdata_d = byte_word(mask_q);
      end else if (rd_count) begin
         rdata_d = count_word(level);
      end
   end

   assign reg_rdata = rdata_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end
endmodule

// ==== hw/xfer_status_pkg.sv ====
// Constants and types for the transfer status queue
// Functional notes
// - Status bits 7..4 show the head record's endpoint number, 0 to 15.
// - Status bit 3 is one for a transmit transfer, zero for receive.
// - Status bit 2 is one for the odd descriptor bank, zero for even.
// - Status bits 31..8 and 1..0 always read as zero.
// - Records queue first-in first-out, four deep; only the oldest is shown.
// - Clearing the transfer-complete flag pops the oldest record.
package xfer_status_pkg;
   localparam int         DATA_W         = 32;
   localparam int         ADDR_W         = 4;
   localparam int         FIFO_DEPTH     = 4;
   localparam int         EP_W           = 4;
   localparam int         REC_W          = 6;
   localparam int         EP_LSB         = 4;
   localparam int         DIR_BIT        = 3;
   localparam int         BANK_BIT       = 2;
   localparam int         FLAG_W         = 8;
   localparam int         REC_DIR_POS    = 1;
   localparam int         REC_BANK_POS   = 0;
   localparam int         TRN_FLAG_BIT   = 3;
   localparam int         OVF_FLAG_BIT   = 0;
   localparam logic [3:0] ADDR_STATUS    = 4'h0;
   localparam logic [3:0] ADDR_FLAGS     = 4'h4;
   localparam logic [3:0] ADDR_MASK      = 4'h8;
   localparam logic [3:0] ADDR_COUNT     = 4'hc;
   localparam logic [7:0] MASK_RESET     = 8'h00;
   localparam logic [7:0] FLAG_USED      = 8'h09;
endpackage

// ==== testbench/usb_transfer_status_fifo_bench.sv ====
// Self-checking bench for the transfer status queue
`timescale 1ns/100ps
module usb_transfer_status_fifo_bench;
   import xfer_status_pkg::*;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic [31:0] reg_rdata;
   logic        done, tx, odd, xfer_ready, transfer_complete_flag, irq;
   logic [3:0]  ep;
   int          failures = 0;
   int          checks = 0;
   int          cyc = 0;
   int          i;
   always #2.5 clock = ~clock;
   usb_transfer_status_fifo i_usb_transfer_status_fifo (.clock(clock), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .xfer_done(done), .xfer_endpoint(ep),
      .xfer_transmit(tx), .xfer_odd_bank(odd), .xfer_ready(xfer_ready),
      .transfer_complete_flag(transfer_complete_flag), .irq(irq));
   xfer_engine_model i_xfer_engine_model (.clock(clock), .xfer_done(done),
      .xfer_endpoint(ep), .xfer_transmit(tx), .xfer_odd_bank(odd));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      {reg_read, reg_addr} <= {1'b1, a};
      @(posedge clock);
      reg_read <= 1'b0;
      #1 check(reg_rdata, e);
   endtask
   function automatic logic [31:0] rec(input int n);
      return {24'h0, 4'(n * 4 + 3), n[0], n[1], 2'h0};
   endfunction
   task automatic finish_test;
      if (failures == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      rd(ADDR_STATUS, 32'h0);
      #1 check({30'h0, xfer_ready, transfer_complete_flag}, 32'h2);
      // Fifth record finds the queue full
      for (i = 0; i < 5; i++) i_xfer_engine_model.send(4'(i * 4 + 3), i[0], i[1]);
      #1 check({30'h0, xfer_ready, irq}, 32'h0);
      rd(ADDR_COUNT, 32'h4);
      wr(ADDR_MASK, 32'hff);
      #1 check({31'h0, irq}, 32'h1);
      rd(ADDR_MASK, 32'h9);
      rd(ADDR_FLAGS, 32'h9);
      rd(ADDR_FLAGS, 32'h8);
      rd(4'h2, 32'h0);
      for (i = 0; i < 4; i++) begin
         rd(ADDR_STATUS, rec(i));
         wr(ADDR_FLAGS, 32'h8);
      end
      // Pop on an empty queue is ignored
      wr(ADDR_FLAGS, 32'h8);
      rd(ADDR_COUNT, 32'h0);
      rd(ADDR_STATUS, 32'h0);
      // Push and pop in one cycle both act
      i_xfer_engine_model.send(4'h6, 1'b1, 1'b1);
      fork
         i_xfer_engine_model.send(4'h9, 1'b0, 1'b1);
         wr(ADDR_FLAGS, 32'h8);
      join
      rd(ADDR_COUNT, 32'h1);
      rd(ADDR_STATUS, 32'h94);
      wr(ADDR_FLAGS, 32'h8);
      #1 check({30'h0, irq, transfer_complete_flag}, 32'h0);
      finish_test();
   end
endmodule

// ==== testbench/xfer_engine_model.sv ====
// Transaction engine model reporting finished transfers
`timescale 1ns/100ps
module xfer_engine_model (
   // Clock
   input wire logic                             clock,
   // Record out
   output logic                                 xfer_done,
   output logic [xfer_status_pkg::EP_W-1:0]     xfer_endpoint,
   output logic                                 xfer_transmit,
   output logic                                 xfer_odd_bank
);
   import xfer_status_pkg::*;
   initial {xfer_done, xfer_endpoint, xfer_transmit, xfer_odd_bank} = 7'h0;
   task automatic send(input logic [3:0] ep, input logic tx, input logic od);
      @(posedge clock);
      xfer_done <= 1'b1;
      {xfer_endpoint, xfer_transmit, xfer_odd_bank} <= {ep, tx, od};
      @(posedge clock);
      xfer_done <= 1'b0;
      // Stale fields must not look valid
      {xfer_endpoint, xfer_transmit, xfer_odd_bank} <= ~{ep, tx, od};
   endtask
endmodule

// ==== testbench/xfer_status_monitor.sv ====
// Port checker for the transfer status queue
`timescale 1ns/100ps
module xfer_status_monitor
   import xfer_status_pkg::*;
(
   // Clock and reset
   input wire logic                               clock,
   input wire logic                               sys_rst,
   // Register port
   input wire logic [xfer_status_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [xfer_status_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                               reg_write,
   input wire logic                               reg_read,
   input wire logic [xfer_status_pkg::DATA_W-1:0] reg_rdata,
   // Engine side and status
   input wire logic                               xfer_done,
   input wire logic                               xfer_ready,
   input wire logic                               transfer_complete_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   push_sets_flag_a: assert property (xfer_done && xfer_ready |=> transfer_complete_flag)
      else $error("flag low after push");
   full_not_empty_a: assert property (!xfer_ready |-> transfer_complete_flag)
      else $error("full while empty");
   rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside answer");
   status_pad_a: assert property ($past(reg_read) && $past(reg_addr) == ADDR_STATUS
      |-> reg_rdata[31:8] == 24'h0 && reg_rdata[1:0] == 2'h0)
      else $error("status pad bits set");
   empty_status_a: assert property ($past(reg_read) && $past(reg_addr) == ADDR_STATUS
      && !$past(transfer_complete_flag) |-> reg_rdata == 32'h0)
      else $error("status shown while empty");
   flag_bit_a: assert property ($past(reg_read) && $past(reg_addr) == ADDR_FLAGS
      |-> reg_rdata[3] == $past(transfer_complete_flag))
      else $error("flag bit differs from flag");
   rise_cause_a: assert property ($rose(transfer_complete_flag) |-> $past(xfer_done))
      else $error("flag rose without push");
   fall_cause_a: assert property ($fell(transfer_complete_flag) |-> $past(reg_write)
      && $past(reg_addr) == ADDR_FLAGS && ($past(reg_wdata) & 32'h8) != 32'h0)
      else $error("flag fell without pop");
endmodule
bind usb_transfer_status_fifo xfer_status_monitor i_xfer_status_monitor (.clock(clock),
   .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .xfer_done(xfer_done), .xfer_ready(xfer_ready),
   .transfer_complete_flag(transfer_complete_flag));
